// ===== logic/iprl_pkg.sv
// Constants, types and source table for the interrupt priority registers
// ==========================================================================
// Overview of operation
// - Code 111 gives level 7, the highest
// - Code 001 gives level 1, lowest active
// - Code 000 disables the source entirely
// - Every field resets to priority 4
// - Unimplemented bits always read as zero
// - Reg 0: timer1, compare1, capture1, ext0
// - Reg 1: timer2, compare2, capture2; low nibble empty
// - Reg 2: serial rx, sync event, fault, timer3
// - Reg 3: bits 15-7 empty; adc, serial tx
// - Reg 4: pin change, comparator, two-wire events
// - Reg 5: capture8, capture7, ext1; 7-3 empty
package iprl_pkg;

  // ========================================================================
  // Widths
  localparam int IPRL_NUM_REGS = 6;
  localparam int IPRL_NUM_SRC  = 20;
  localparam int IPRL_FIELD_W  = 3;
  localparam int IPRL_REG_W    = 16;
  localparam int IPRL_DATA_W   = 32;
  localparam int IPRL_ADDR_W   = 8;
  localparam int IPRL_STRB_W   = 4;
  localparam int IPRL_IDX_W    = 3;

  // ========================================================================
  // Register map
  localparam logic [IPRL_ADDR_W-1:0] IPRL_REG_OFFS [IPRL_NUM_REGS] =
    '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
  typedef logic [IPRL_NUM_REGS-1:0][IPRL_REG_W-1:0] iprl_regs_t;
  localparam iprl_regs_t IPRL_IMPL_MASK =
    {16'h7707, 16'h7777, 16'h0077, 16'h7777, 16'h7770, 16'h7777};
  localparam iprl_regs_t IPRL_RST_REGS =
    {16'h4404, 16'h4444, 16'h0044, 16'h4444, 16'h4440, 16'h4444};
  localparam logic [IPRL_REG_W-1:0] IPRL_SPARE_BITS = 16'h8888;

  // Field positions inside a register
  localparam int IPRL_HI_LSB = 12;
  localparam int IPRL_MH_LSB = 8;
  localparam int IPRL_ML_LSB = 4;
  localparam int IPRL_LO_LSB = 0;

  // Codes and bus answers
  localparam logic [IPRL_FIELD_W-1:0] IPRL_CODE_OFF = 3'h0;
  localparam logic [IPRL_FIELD_W-1:0] IPRL_CODE_MIN = 3'h1;
  localparam logic [IPRL_FIELD_W-1:0] IPRL_CODE_MAX = 3'h7;
  localparam logic [IPRL_FIELD_W-1:0] IPRL_RST_FIELD = 3'h4;
  localparam logic [1:0] IPRL_RESP_OKAY   = 2'h0;
  localparam logic [1:0] IPRL_RESP_SLVERR = 2'h2;

  // ========================================================================
  // Source indices on the level outputs
  localparam int IPRL_TIMER_ONE_PRIO            = 0;
  localparam int IPRL_COMPARE_ONE_PRIO          = 1;
  localparam int IPRL_CAPTURE_ONE_PRIO          = 2;
  localparam int IPRL_EXT_IRQ_ZERO_PRIO         = 3;
  localparam int IPRL_TIMER_TWO_PRIO            = 4;
  localparam int IPRL_COMPARE_TWO_PRIO          = 5;
  localparam int IPRL_CAPTURE_TWO_PRIO          = 6;
  localparam int IPRL_SERIAL_ONE_RX_PRIO        = 7;
  localparam int IPRL_SYNC_SERIAL_ONE_EVENT_PRIO = 8;
  localparam int IPRL_SYNC_SERIAL_ONE_FAULT_PRIO = 9;
  localparam int IPRL_TIMER_THREE_PRIO          = 10;
  localparam int IPRL_ADC_DONE_PRIO             = 11;
  localparam int IPRL_SERIAL_ONE_TX_PRIO        = 12;
  localparam int IPRL_PIN_CHANGE_PRIO           = 13;
  localparam int IPRL_COMPARATOR_PRIO           = 14;
  localparam int IPRL_TWOWIRE_ONE_MASTER_PRIO   = 15;
  localparam int IPRL_TWOWIRE_ONE_SLAVE_PRIO    = 16;
  localparam int IPRL_CAPTURE_EIGHT_PRIO        = 17;
  localparam int IPRL_CAPTURE_SEVEN_PRIO        = 18;
  localparam int IPRL_EXT_IRQ_ONE_PRIO          = 19;

  // Register and field of each source
  localparam int IPRL_SRC_REG [IPRL_NUM_SRC] =
    '{0, 0, 0, 0, 1, 1, 1, 2, 2, 2, 2, 3, 3, 4, 4, 4, 4, 5, 5, 5};
  localparam int IPRL_SRC_LSB [IPRL_NUM_SRC] =
    '{IPRL_HI_LSB, IPRL_MH_LSB, IPRL_ML_LSB, IPRL_LO_LSB,
      IPRL_HI_LSB, IPRL_MH_LSB, IPRL_ML_LSB,
      IPRL_HI_LSB, IPRL_MH_LSB, IPRL_ML_LSB, IPRL_LO_LSB,
      IPRL_ML_LSB, IPRL_LO_LSB,
      IPRL_HI_LSB, IPRL_MH_LSB, IPRL_ML_LSB, IPRL_LO_LSB,
      IPRL_HI_LSB, IPRL_MH_LSB, IPRL_LO_LSB};

  // ========================================================================
  // Types
  typedef enum logic {IPRL_WR_COLLECT, IPRL_WR_RESP} iprl_wr_state_t;
  typedef enum logic {IPRL_RD_ADDR, IPRL_RD_DATA} iprl_rd_state_t;

  typedef struct packed {
    iprl_regs_t                regs;
    iprl_wr_state_t            wr_state;
    iprl_rd_state_t            rd_state;
    logic                      aw_got;
    logic                      w_got;
    logic [IPRL_ADDR_W-1:0]    aw_addr;
    logic [IPRL_DATA_W-1:0]    w_data;
    logic [IPRL_STRB_W-1:0]    w_strb;
    logic                      awready;
    logic                      wready;
    logic                      bvalid;
    logic [1:0]                bresp;
    logic                      arready;
    logic                      rvalid;
    logic [IPRL_DATA_W-1:0]    rdata;
    logic [1:0]                rresp;
  } iprl_state_t;

  typedef struct packed {
    logic [IPRL_FIELD_W-1:0] level;
    logic                    active;
  } iprl_lvl_state_t;

  // Field of one source out of the register set
  function automatic logic [IPRL_FIELD_W-1:0] iprl_field(input iprl_regs_t regs, input int src);
    return regs[IPRL_SRC_REG[src]][IPRL_SRC_LSB[src] +: IPRL_FIELD_W];
  endfunction

endpackage

// ===== logic/iprl_level.sv
// Registered decode of one three-bit priority field
module iprl_level (
  input  wire logic                              sys_clk,
  input  wire logic                              rst_b,
  input  wire logic                              ce,
  input  wire logic [iprl_pkg::IPRL_FIELD_W-1:0] code,
  output logic      [iprl_pkg::IPRL_FIELD_W-1:0] level,
  output logic                                   active
);
  import iprl_pkg::*;

  iprl_lvl_state_t lvl_reg;
  iprl_lvl_state_t lvl_next;

  // ========================================================================
  // Decode
  always_comb begin
    lvl_next = lvl_reg;
    lvl_next.level = code;
    lvl_next.active = (code != IPRL_CODE_OFF);
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      lvl_reg <= '{level: IPRL_RST_FIELD, active: 1'b1};
    end else if (ce) begin
      lvl_reg <= lvl_next;
    end
  end

  assign level  = lvl_reg.level;
  assign active = lvl_reg.active;

  // ========================================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  chk_top_level: assert property ($past(ce) && $past(code) == IPRL_CODE_MAX |-> level == 3'h7 && active)
    else $error("code 111 did not give level 7");
  chk_low_level: assert property ($past(ce) && $past(code) == IPRL_CODE_MIN |-> level == 3'h1 && active)
    else $error("code 001 did not give active level 1");
  chk_off_code: assert property ($past(ce) && $past(code) == IPRL_CODE_OFF |-> !active)
    else $error("code 000 left source active");
  chk_linear_map: assert property ($past(ce) && $past(code) > IPRL_CODE_MIN && $past(code) < IPRL_CODE_MAX
    |-> level == $past(code) && active)
    else $error("middle code not mapped linearly");
endmodule

// ===== logic/iprl_regs.sv
// Top: AXI4-Lite slave holding six interrupt priority registers
module iprl_regs (
  input  wire logic                                                    SYS_CLK,
  input  wire logic                                                    RST_B,
  input  wire logic                                                    CE,
  input  wire logic [iprl_pkg::IPRL_ADDR_W-1:0]                        AWADDR,
  input  wire logic                                                    AWVALID,
  output logic                                                         AWREADY,
  input  wire logic [iprl_pkg::IPRL_DATA_W-1:0]                        WDATA,
  input  wire logic [iprl_pkg::IPRL_STRB_W-1:0]                        WSTRB,
  input  wire logic                                                    WVALID,
  output logic                                                         WREADY,
  output logic      [1:0]                                              BRESP,
  output logic                                                         BVALID,
  input  wire logic                                                    BREADY,
  input  wire logic [iprl_pkg::IPRL_ADDR_W-1:0]                        ARADDR,
  input  wire logic                                                    ARVALID,
  output logic                                                         ARREADY,
  output logic      [iprl_pkg::IPRL_DATA_W-1:0]                        RDATA,
  output logic      [1:0]                                              RRESP,
  output logic                                                         RVALID,
  input  wire logic                                                    RREADY,
  output logic      [iprl_pkg::IPRL_NUM_SRC-1:0][iprl_pkg::IPRL_FIELD_W-1:0] PRIO_LEVEL,
  output logic      [iprl_pkg::IPRL_NUM_SRC-1:0]                       PRIO_ACTIVE
);
  import iprl_pkg::*;

  localparam iprl_state_t ST_RST = '{
    regs:     IPRL_RST_REGS,
    wr_state: IPRL_WR_COLLECT,
    rd_state: IPRL_RD_ADDR,
    default:  '0
  };

  iprl_state_t st_reg;
  iprl_state_t st_next;

  logic                   aw_take;
  logic                   w_take;
  logic                   ar_take;
  logic                   have_aw;
  logic                   have_w;
  logic [IPRL_IDX_W:0]    wr_dec;
  logic [IPRL_IDX_W:0]    rd_dec;

  // ========================================================================
  // Helpers
  // Hit flag on top, register index below
  function automatic logic [IPRL_IDX_W:0] decode_addr(input logic [IPRL_ADDR_W-1:0] addr);
    logic [IPRL_IDX_W:0] res;
    res = '0;
    for (int i = 0; i < IPRL_NUM_REGS; i++) begin
      if (addr[IPRL_ADDR_W-1:2] == IPRL_REG_OFFS[i][IPRL_ADDR_W-1:2]) begin
        res = {1'b1, IPRL_IDX_W'(i)};
      end
    end
    return res;
  endfunction

  // Byte-lane merge, then drop unimplemented bits
  function automatic logic [IPRL_REG_W-1:0] merge_word(
    input logic [IPRL_REG_W-1:0]  old_val,
    input logic [IPRL_DATA_W-1:0] data,
    input logic [IPRL_STRB_W-1:0] strb,
    input logic [IPRL_REG_W-1:0]  mask
  );
    logic [IPRL_REG_W-1:0] val;
    val = old_val;
    for (int b = 0; b < IPRL_REG_W / 8; b++) begin
      if (strb[b]) begin
        val[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return val & mask;
  endfunction

  // ========================================================================
  // Next state
  always_comb begin
    st_next = st_reg;
    aw_take = AWVALID && st_reg.awready;
    w_take  = WVALID && st_reg.wready;
    ar_take = ARVALID && st_reg.arready;
    have_aw = st_reg.aw_got || aw_take;
    have_w  = st_reg.w_got || w_take;
    wr_dec  = '0;
    rd_dec  = decode_addr(ARADDR);

    // Write channel: address and data in either order
    case (st_reg.wr_state)
      IPRL_WR_COLLECT: begin
        if (aw_take) begin
          st_next.aw_got  = 1'b1;
          st_next.aw_addr = AWADDR;
        end
        if (w_take) begin
          st_next.w_got  = 1'b1;
          st_next.w_data = WDATA;
          st_next.w_strb = WSTRB;
        end
        if (have_aw && have_w) begin
          wr_dec = decode_addr(st_next.aw_addr);
          if (wr_dec[IPRL_IDX_W]) begin
            st_next.regs[wr_dec[IPRL_IDX_W-1:0]] = merge_word(
              st_reg.regs[wr_dec[IPRL_IDX_W-1:0]],
              st_next.w_data,
              st_next.w_strb,
              IPRL_IMPL_MASK[wr_dec[IPRL_IDX_W-1:0]]);
            st_next.bresp = IPRL_RESP_OKAY;
          end else begin
            st_next.bresp = IPRL_RESP_SLVERR;
          end
          st_next.aw_got   = 1'b0;
          st_next.w_got    = 1'b0;
          st_next.bvalid   = 1'b1;
          st_next.wr_state = IPRL_WR_RESP;
        end
      end
      IPRL_WR_RESP: begin
        if (BREADY) begin
          st_next.bvalid   = 1'b0;
          st_next.wr_state = IPRL_WR_COLLECT;
        end
      end
      default: begin
        st_next.wr_state = IPRL_WR_COLLECT;
      end
    endcase
    st_next.awready = (st_next.wr_state == IPRL_WR_COLLECT) && !st_next.aw_got;
    st_next.wready  = (st_next.wr_state == IPRL_WR_COLLECT) && !st_next.w_got;

    // Read channel
    case (st_reg.rd_state)
      IPRL_RD_ADDR: begin
        if (ar_take) begin
          if (rd_dec[IPRL_IDX_W]) begin
            st_next.rdata = {{(IPRL_DATA_W - IPRL_REG_W){1'b0}},
                             st_reg.regs[rd_dec[IPRL_IDX_W-1:0]]};
            st_next.rresp = IPRL_RESP_OKAY;
          end else begin
            st_next.rdata = '0;
            st_next.rresp = IPRL_RESP_SLVERR;
          end
          st_next.rvalid   = 1'b1;
          st_next.rd_state = IPRL_RD_DATA;
        end
      end
      IPRL_RD_DATA: begin
        if (RREADY) begin
          st_next.rvalid   = 1'b0;
          st_next.rd_state = IPRL_RD_ADDR;
        end
      end
      default: begin
        st_next.rd_state = IPRL_RD_ADDR;
      end
    endcase
    st_next.arready = (st_next.rd_state == IPRL_RD_ADDR);
  end

  // ========================================================================
  // State register
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      st_reg <= ST_RST;
    end else if (CE) begin
      st_reg <= st_next;
    end
  end

  assign AWREADY = st_reg.awready;
  assign WREADY  = st_reg.wready;
  assign BVALID  = st_reg.bvalid;
  assign BRESP   = st_reg.bresp;
  assign ARREADY = st_reg.arready;
  assign RVALID  = st_reg.rvalid;
  assign RDATA   = st_reg.rdata;
  assign RRESP   = st_reg.rresp;

  // ========================================================================
  // Per-source level decode
  generate
    for (genvar s = 0; s < IPRL_NUM_SRC; s++) begin : g_src
      iprl_level u_level (
        .sys_clk (SYS_CLK),
        .rst_b   (RST_B),
        .ce      (CE),
        .code    (iprl_field(st_reg.regs, s)),
        .level   (PRIO_LEVEL[s]),
        .active  (PRIO_ACTIVE[s])
      );
    end
  endgenerate

  // ========================================================================
  // Checks
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);

  sequence s_write_done;
    CE && st_reg.wr_state == IPRL_WR_COLLECT && have_aw && have_w;
  endsequence

  sequence s_resp_up;
    BVALID && !AWREADY && !WREADY;
  endsequence

  chk_write_resp: assert property (s_write_done |=> s_resp_up)
    else $error("write response missing after both halves taken");

  chk_reset_value: assert property (!$past(RST_B) |-> st_reg.regs == 96'h4404_4444_0044_4444_4440_4444)
    else $error("priority fields not at level 4 after reset");

  chk_read_zero: assert property (RVALID |-> RDATA[31:16] == '0 && (RDATA[15:0] & IPRL_SPARE_BITS) == '0)
    else $error("unimplemented bit read as one");

  generate
    for (genvar r = 0; r < IPRL_NUM_REGS; r++) begin : g_chk
      chk_unimpl_hold: assert property ((st_reg.regs[r] & ~IPRL_IMPL_MASK[r]) == '0)
        else $error("unimplemented bit took a write");
    end
  endgenerate

  chk_reg0_map: assert property ($past(CE) |->
    PRIO_LEVEL[IPRL_TIMER_ONE_PRIO] == $past(st_reg.regs[0][IPRL_HI_LSB +: 3]) &&
    PRIO_LEVEL[IPRL_COMPARE_ONE_PRIO] == $past(st_reg.regs[0][IPRL_MH_LSB +: 3]) &&
    PRIO_LEVEL[IPRL_CAPTURE_ONE_PRIO] == $past(st_reg.regs[0][IPRL_ML_LSB +: 3]) &&
    PRIO_LEVEL[IPRL_EXT_IRQ_ZERO_PRIO] == $past(st_reg.regs[0][IPRL_LO_LSB +: 3]))
    else $error("register 0 fields misplaced");

  chk_reg1_map: assert property ($past(CE) |->
    PRIO_LEVEL[IPRL_TIMER_TWO_PRIO] == $past(st_reg.regs[1][IPRL_HI_LSB +: 3]) &&
    PRIO_LEVEL[IPRL_COMPARE_TWO_PRIO] == $past(st_reg.regs[1][IPRL_MH_LSB +: 3]) &&
    PRIO_LEVEL[IPRL_CAPTURE_TWO_PRIO] == $past(st_reg.regs[1][IPRL_ML_LSB +: 3]) &&
    st_reg.regs[1][3:0] == '0)
    else $error("register 1 fields misplaced");

  chk_reg2_map: assert property ($past(CE) |->
    PRIO_LEVEL[IPRL_SERIAL_ONE_RX_PRIO] == $past(st_reg.regs[2][IPRL_HI_LSB +: 3]) &&
    PRIO_LEVEL[IPRL_SYNC_SERIAL_ONE_EVENT_PRIO] == $past(st_reg.regs[2][IPRL_MH_LSB +: 3]) &&
    PRIO_LEVEL[IPRL_SYNC_SERIAL_ONE_FAULT_PRIO] == $past(st_reg.regs[2][IPRL_ML_LSB +: 3]) &&
    PRIO_LEVEL[IPRL_TIMER_THREE_PRIO] == $past(st_reg.regs[2][IPRL_LO_LSB +: 3]))
    else $error("register 2 fields misplaced");

  chk_reg3_map: assert property ($past(CE) |->
    PRIO_LEVEL[IPRL_ADC_DONE_PRIO] == $past(st_reg.regs[3][IPRL_ML_LSB +: 3]) &&
    PRIO_LEVEL[IPRL_SERIAL_ONE_TX_PRIO] == $past(st_reg.regs[3][IPRL_LO_LSB +: 3]) &&
    st_reg.regs[3][15:7] == '0)
    else $error("register 3 fields misplaced");

  chk_reg4_map: assert property ($past(CE) |->
    PRIO_LEVEL[IPRL_PIN_CHANGE_PRIO] == $past(st_reg.regs[4][IPRL_HI_LSB +: 3]) &&
    PRIO_LEVEL[IPRL_COMPARATOR_PRIO] == $past(st_reg.regs[4][IPRL_MH_LSB +: 3]) &&
    PRIO_LEVEL[IPRL_TWOWIRE_ONE_MASTER_PRIO] == $past(st_reg.regs[4][IPRL_ML_LSB +: 3]) &&
    PRIO_LEVEL[IPRL_TWOWIRE_ONE_SLAVE_PRIO] == $past(st_reg.regs[4][IPRL_LO_LSB +: 3]))
    else $error("register 4 fields misplaced");

  chk_reg5_map: assert property ($past(CE) |->
    PRIO_LEVEL[IPRL_CAPTURE_EIGHT_PRIO] == $past(st_reg.regs[5][IPRL_HI_LSB +: 3]) &&
    PRIO_LEVEL[IPRL_CAPTURE_SEVEN_PRIO] == $past(st_reg.regs[5][IPRL_MH_LSB +: 3]) &&
    PRIO_LEVEL[IPRL_EXT_IRQ_ONE_PRIO] == $past(st_reg.regs[5][IPRL_LO_LSB +: 3]) &&
    st_reg.regs[5][7:3] == '0)
    else $error("register 5 fields misplaced");
endmodule

// ===== sim/iprl_regs_bench.sv
// Self-checking bench for the interrupt priority register block
module iprl_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import iprl_pkg::*;

  // ==========================================================================
  // Design signals
  logic                                      SYS_CLK = 1'b0;
  logic                                      RST_B;
  logic                                      CE;
  logic [IPRL_ADDR_W-1:0]                    AWADDR, ARADDR;
  logic                                      AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
  logic                                      ARVALID, ARREADY, RVALID, RREADY;
  logic [IPRL_DATA_W-1:0]                    WDATA, RDATA;
  logic [IPRL_STRB_W-1:0]                    WSTRB;
  logic [1:0]                                BRESP, RRESP;
  logic [IPRL_NUM_SRC-1:0][IPRL_FIELD_W-1:0] PRIO_LEVEL;
  logic [IPRL_NUM_SRC-1:0]                   PRIO_ACTIVE;
  int                                        error_cnt = 0;
  int                                        n_checks = 0;
  logic [15:0]                               exp_reg [6];

  // Implemented field slots per register, slot k at bit 4k
  localparam logic [3:0] slot_tbl [6] = '{4'hF, 4'hE, 4'hF, 4'h3, 4'hF, 4'hD};
  localparam int src_reg_tbl [20] = '{0, 0, 0, 0, 1, 1, 1, 2, 2, 2, 2, 3, 3, 4, 4, 4, 4, 5, 5, 5};
  localparam int src_lsb_tbl [20] = '{12, 8, 4, 0, 12, 8, 4, 12, 8, 4, 0, 4, 0, 12, 8, 4, 0, 12, 8, 0};

  iprl_regs i_iprl_regs (
    .SYS_CLK(SYS_CLK), .RST_B(RST_B), .CE(CE),
    .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
    .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
    .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
    .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
    .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
    .PRIO_LEVEL(PRIO_LEVEL), .PRIO_ACTIVE(PRIO_ACTIVE)
  );

  always #12.5 SYS_CLK = ~SYS_CLK;

  // ==========================================================================
  // Compare and closing tasks
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_code(input logic [2:0] got, input logic [2:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    if (error_cnt == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================================
  // Bus tasks; entered and left just after a rising edge
  task automatic axi_write(input logic [7:0] addr, input logic [31:0] data, input logic [3:0] strb,
                           output logic [1:0] resp);
    logic aw_hit, w_hit, b_hit;
    AWADDR <= addr;
    AWVALID <= 1'b1;
    WDATA <= data;
    WSTRB <= strb;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    b_hit = 1'b0;
    while (!b_hit) begin
      @(negedge SYS_CLK);
      aw_hit = AWVALID && AWREADY;
      w_hit = WVALID && WREADY;
      b_hit = BVALID && BREADY;
      resp = BRESP;
      @(posedge SYS_CLK);
      if (aw_hit) AWVALID <= 1'b0;
      if (w_hit) WVALID <= 1'b0;
    end
    BREADY <= 1'b0;
    @(posedge SYS_CLK);
  endtask

  task automatic axi_read(input logic [7:0] addr, output logic [31:0] data, output logic [1:0] resp);
    logic ar_hit, r_hit;
    ARADDR <= addr;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    r_hit = 1'b0;
    while (!r_hit) begin
      @(negedge SYS_CLK);
      ar_hit = ARVALID && ARREADY;
      r_hit = RVALID && RREADY;
      data = RDATA;
      resp = RRESP;
      @(posedge SYS_CLK);
      if (ar_hit) ARVALID <= 1'b0;
    end
    RREADY <= 1'b0;
    @(posedge SYS_CLK);
  endtask

  // Field code replicated into every implemented slot of a register
  function automatic logic [15:0] fill(input logic [2:0] code, input int r);
    logic [15:0] v;
    v = 16'h0000;
    for (int k = 0; k < 4; k++) if (slot_tbl[r][k]) v[4*k +: 3] = code;
    return v;
  endfunction

  task automatic wr_reg(input int r, input logic [31:0] d, input logic [3:0] s);
    logic [1:0] resp;
    axi_write(8'(4 * r), d, s, resp);
    cmp_resp(resp, IPRL_RESP_OKAY);
  endtask

  task automatic chk_reg(input int r, input logic [15:0] exp);
    logic [31:0] d;
    logic [1:0]  resp;
    axi_read(8'(4 * r), d, resp);
    cmp_resp(resp, IPRL_RESP_OKAY);
    cmp_word(d, {16'h0000, exp});
  endtask

  task automatic chk_levels(input logic [2:0] code);
    repeat (2) @(posedge SYS_CLK);
    for (int s = 0; s < IPRL_NUM_SRC; s++) begin
      cmp_code(PRIO_LEVEL[s], code);
      cmp_code({2'b00, PRIO_ACTIVE[s]}, {2'b00, code != 3'h0});
    end
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    for (int r = 0; r < 6; r++) chk_reg(r, fill(3'h4, r));
    chk_levels(3'h4);
  endtask

  task automatic t_all_ones();
    for (int r = 0; r < 6; r++) wr_reg(r, 32'hFFFF_FFFF, 4'hF);
    for (int r = 0; r < 6; r++) chk_reg(r, fill(3'h7, r));
    chk_levels(3'h7);
  endtask

  task automatic t_codes();
    for (int c = 0; c < 8; c++) begin
      for (int r = 0; r < 6; r++) wr_reg(r, {16'h0000, {4{1'b0, 3'(c)}}}, 4'h3);
      chk_reg(c % 6, fill(3'(c), c % 6));
      chk_levels(3'(c));
    end
  endtask

  task automatic t_map();
    logic [15:0] d;
    for (int r = 0; r < 6; r++) begin
      d = 16'h0000;
      for (int k = 0; k < 4; k++) d[4*k +: 3] = 3'((r + k + 1) % 8);
      exp_reg[r] = d & fill(3'h7, r);
      wr_reg(r, {16'hFFFF, d}, 4'hF);
    end
    repeat (2) @(posedge SYS_CLK);
    for (int s = 0; s < IPRL_NUM_SRC; s++)
      cmp_code(PRIO_LEVEL[s], 3'(exp_reg[src_reg_tbl[s]] >> src_lsb_tbl[s]));
    for (int r = 0; r < 6; r++) chk_reg(r, exp_reg[r]);
  endtask

  task automatic t_strobe_unmapped();
    logic [31:0] d;
    logic [1:0]  resp;
    wr_reg(2, 32'h0000_FFFF, 4'h1);
    chk_reg(2, (exp_reg[2] & 16'hFF00) | 16'h0077);
    wr_reg(2, 32'h0000_0000, 4'h2);
    chk_reg(2, 16'h0077);
    axi_write(8'h18, 32'h0000_0000, 4'hF, resp);
    cmp_resp(resp, IPRL_RESP_SLVERR);
    axi_read(8'hFC, d, resp);
    cmp_resp(resp, IPRL_RESP_SLVERR);
    cmp_word(d, 32'h0000_0000);
    chk_reg(0, exp_reg[0]);
  endtask

  // Clock enable low: a pending read is neither taken nor answered
  task automatic t_freeze();
    logic [31:0] d;
    logic [1:0]  resp;
    CE <= 1'b0;
    ARADDR <= 8'h00;
    ARVALID <= 1'b1;
    repeat (4) @(posedge SYS_CLK);
    cmp_resp({ARREADY, RVALID}, 2'b10);
    CE <= 1'b1;
    axi_read(8'h00, d, resp);
    cmp_resp(resp, IPRL_RESP_OKAY);
    cmp_word(d, {16'h0000, exp_reg[0]});
  endtask

  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    RST_B = 1'b0;
    CE = 1'b1;
    AWADDR = '0;
    AWVALID = 1'b0;
    WDATA = '0;
    WSTRB = '0;
    WVALID = 1'b0;
    BREADY = 1'b0;
    ARADDR = '0;
    ARVALID = 1'b0;
    RREADY = 1'b0;
    repeat (5) @(posedge SYS_CLK);
    RST_B <= 1'b1;
    @(posedge SYS_CLK);
    t_reset();
    t_all_ones();
    t_codes();
    t_map();
    t_strobe_unmapped();
    t_freeze();
    end_of_test();
  end

  initial begin
    #500us;
    error_cnt++;
    end_of_test();
  end
endmodule
